// [logic/prescaled_down_timer.sv]
// prescaled 8-bit down timer with control register and option word
`timescale 1ns/1ps
module prescaled_down_timer
  import prescaled_down_timer_pkg::*;
#(
  parameter logic [7:0] OPTION_WORD = OPTION_ERASED
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStrobe,
  input  wire logic        rdStrobe,
  output logic      [7:0]  rdData,
  input  wire logic        timerPin,
  input  wire logic        cpuIntMask,
  output logic             timerIrq,
  output logic             oscIsRc,
  output logic      [7:0]  countValue
);

  typedef struct packed {
    logic       countIrqRequest;
    logic       countIrqMask;
    logic       countClockSelect;
    logic       extPinEnable;
    logic [2:0] divSelect;
    logic       initDone;
    logic       countLoaded;
    logic [1:0] phaseCnt;
    logic [6:0] prescaler;
    logic       pinPrev;
    logic [7:0] rdData;
    logic       timerIrq;
  } ctrl_t;

  // count lives outside the reset state so no reset touches it
  logic [7:0] countReg;
  logic [7:0] countNext;
  ctrl_t      s_reg;
  ctrl_t      s_next;

  logic       legacy;
  logic       srcSel;
  logic       pinEn;
  logic [2:0] divSel;
  logic       phaseTick;
  logic       preTick;
  logic [6:0] preNext;
  logic       tapPulse;
  logic       wrCtrl;
  logic       wrCount;

  // the option word is fixed; reset never changes it
  assign legacy = OPTION_WORD[LEGACY_BIT];

  // tap selection: bit n of prescaler toggling high means divide by 2^(n+1)
  function automatic logic tapRise(input logic [6:0] oldV, input logic [6:0] newV,
                                   input logic [2:0] sel, input logic tick);
    logic r;
    r = 1'b0;
    if (sel == 3'h0) begin
      r = tick;
    end else begin
      r = tick && newV[sel - 3'h1] && !oldV[sel - 3'h1];
    end
    return r;
  endfunction

  // effective mode bits, legacy forces pin enable
  always_comb begin
    srcSel = s_reg.countClockSelect;
    pinEn  = legacy ? 1'b1 : s_reg.extPinEnable;
    divSel = s_reg.divSelect;
  end

  // next-state logic
  always_comb begin
    s_next    = s_reg;
    countNext = countReg;
    wrCtrl    = wrStrobe && (addr == COUNT_CONTROL_ADDR);
    wrCount   = wrStrobe && (addr == COUNT_VALUE_ADDR);
    phaseTick = (s_reg.phaseCnt == PHASE_DIV);
    s_next.phaseCnt = s_reg.phaseCnt + 2'h1;
    s_next.pinPrev  = timerPin;

    // one-time load of control from option word after reset release
    if (!s_reg.initDone) begin
      s_next.initDone         = 1'b1;
      s_next.countClockSelect = OPTION_WORD[SRC_BIT];
      s_next.extPinEnable     = OPTION_WORD[PIN_EN_BIT];
      s_next.divSelect        = OPTION_WORD[2:0];
    end

    // prescaler input select
    unique case ({pinEn, srcSel})
      2'b00:   preTick = phaseTick;
      2'b10:   preTick = phaseTick && timerPin;
      2'b01:   preTick = 1'b0;
      2'b11:   preTick = timerPin && !s_reg.pinPrev;
    endcase
    preNext  = s_reg.prescaler + {6'h0, preTick};
    tapPulse = tapRise(s_reg.prescaler, preNext, divSel, preTick);
    s_next.prescaler = preNext;

    // control register write
    if (wrCtrl) begin
      s_next.countIrqMask = wrData[MASK_BIT];
      if (!wrData[REQ_BIT]) begin
        s_next.countIrqRequest = 1'b0;
      end
      if (!legacy) begin
        s_next.countClockSelect = wrData[SRC_BIT];
        s_next.extPinEnable     = wrData[PIN_EN_BIT];
        s_next.divSelect        = wrData[2:0];
        if (wrData[PS_CLR_BIT]) begin
          s_next.prescaler = 7'h0;
          tapPulse         = 1'b0;
        end
      end
    end

    // counter: load wins, else one step per tap pulse
    if (wrCount) begin
      countNext          = wrData;
      s_next.countLoaded = 1'b1;
    end else if (tapPulse) begin
      countNext = countReg - 8'h1;
      if (countReg == 8'h01) begin
        s_next.countIrqRequest = 1'b1;
      end
    end

    s_next.timerIrq = s_reg.countIrqRequest && !s_reg.countIrqMask && !cpuIntMask;

    // read mux, one cycle latency
    s_next.rdData = s_reg.rdData;
    if (rdStrobe) begin
      unique case (addr)
        COUNT_VALUE_ADDR:   s_next.rdData = countReg;
        COUNT_CONTROL_ADDR: begin
          if (legacy) begin
            s_next.rdData = {s_reg.countIrqRequest, s_reg.countIrqMask, 6'h3f};
          end else begin
            s_next.rdData = {s_reg.countIrqRequest, s_reg.countIrqMask,
                             s_reg.countClockSelect, s_reg.extPinEnable, 1'b0,
                             s_reg.divSelect};
          end
        end
        EPROM_PROG_ADDR:    s_next.rdData = EPROM_PROG_RST;
        OPTION_WORD_ADDR:   s_next.rdData = OPTION_WORD;
        default:            s_next.rdData = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_reg                 <= '0;
      s_reg.countIrqRequest <= 1'b0;
      s_reg.countIrqMask    <= 1'b1;
      s_reg.divSelect       <= DIV_SEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // count register, deliberately without reset
  always_ff @(posedge ref_clk) begin
    countReg <= countNext;
  end

  // output copies
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      oscIsRc    <= 1'b0;
      countValue <= COUNT_INIT;
    end else begin
      oscIsRc    <= OPTION_WORD[OSC_BIT];
      countValue <= countNext;
    end
  end

  assign rdData   = s_reg.rdData;
  assign timerIrq = s_reg.timerIrq;

  // checks
  // count step that takes the counter from one to zero
  sequence s_one_to_zero;
    tapPulse && !wrCount && countReg == 8'h01;
  endsequence

  // count step taken while the counter is at zero
  sequence s_wrap_step;
    tapPulse && !wrCount && countReg == 8'h00;
  endsequence

  // software read of the control register
  sequence s_ctrl_read;
    rdStrobe && addr == COUNT_CONTROL_ADDR;
  endsequence

  property p_zero_sets_req;
    @(posedge ref_clk) disable iff (reset)
      s_one_to_zero |=> s_reg.countIrqRequest;
  endproperty
  a_zero_sets_req: assert property (p_zero_sets_req) else $error("request not set at zero");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (reset)
      timerIrq |-> $past(s_reg.countIrqRequest) && !$past(s_reg.countIrqMask) && !$past(cpuIntMask);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without cause");

  property p_req_sticky;
    @(posedge ref_clk) disable iff (reset)
      (s_reg.countIrqRequest && !wrCtrl) |=> s_reg.countIrqRequest;
  endproperty
  a_req_sticky: assert property (p_req_sticky) else $error("request dropped");

  property p_step_one;
    @(posedge ref_clk) disable iff (reset)
      (!wrCount && s_reg.countLoaded) |=> (countReg == $past(countReg) - {7'h0, $past(tapPulse)});
  endproperty
  a_step_one: assert property (p_step_one) else $error("bad count step");

  property p_stopped;
    @(posedge ref_clk) disable iff (reset)
      (!legacy && !pinEn && srcSel) |-> !preTick;
  endproperty
  a_stopped: assert property (p_stopped) else $error("prescaler runs in stop mode");

  property p_load;
    @(posedge ref_clk) disable iff (reset)
      wrCount |=> countReg == $past(wrData);
  endproperty
  a_load: assert property (p_load) else $error("load lost");

  property p_psc_clear;
    @(posedge ref_clk) disable iff (reset)
      (wrCtrl && !legacy && wrData[PS_CLR_BIT]) |=> s_reg.prescaler == 7'h0;
  endproperty
  a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (reset)
      (rdStrobe && addr == COUNT_CONTROL_ADDR) |=> (rdData[PS_CLR_BIT] == legacy);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("bit 3 read wrong");

  // wrap, step and output copy checks on the counter
  property p_wrap;
    @(posedge ref_clk) disable iff (reset)
      s_wrap_step |=> countReg == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to ff");

  property p_no_tap_no_step;
    @(posedge ref_clk) disable iff (reset)
      (!wrCount && !tapPulse && s_reg.countLoaded) |=> $stable(countReg);
  endproperty
  a_no_tap_no_step: assert property (p_no_tap_no_step) else $error("count moved without tap");

  property p_count_copy;
    @(posedge ref_clk) disable iff (reset)
      s_reg.countLoaded |-> countValue == countReg;
  endproperty
  a_count_copy: assert property (p_count_copy) else $error("count output differs from counter");

  // read path checks
  property p_live_read;
    @(posedge ref_clk) disable iff (reset)
      (rdStrobe && addr == COUNT_VALUE_ADDR) |=> rdData == $past(countReg);
  endproperty
  a_live_read: assert property (p_live_read) else $error("count read wrong");

  property p_read_hold;
    @(posedge ref_clk) disable iff (reset)
      !rdStrobe |=> $stable(rdData);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved without read");

  property p_ctrl_flags;
    @(posedge ref_clk) disable iff (reset)
      s_ctrl_read |=> (rdData[REQ_BIT] == $past(s_reg.countIrqRequest))
                   && (rdData[MASK_BIT] == $past(s_reg.countIrqMask));
  endproperty
  a_ctrl_flags: assert property (p_ctrl_flags) else $error("control flags read wrong");

  // request flag and interrupt output
  property p_irq_cause;
    @(posedge ref_clk) disable iff (reset)
      (s_reg.countIrqRequest && !s_reg.countIrqMask && !cpuIntMask) |=> timerIrq;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq not raised");

  property p_req_clear;
    @(posedge ref_clk) disable iff (reset)
      (wrCtrl && !wrData[REQ_BIT] && !(tapPulse && !wrCount && countReg == 8'h01))
        |=> !s_reg.countIrqRequest;
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request not cleared");

  // prescaler input modes
  property p_mode_internal;
    @(posedge ref_clk) disable iff (reset)
      ({pinEn, srcSel} == 2'b00) |-> preTick == phaseTick;
  endproperty
  a_mode_internal: assert property (p_mode_internal) else $error("internal mode input wrong");

  property p_mode_gated;
    @(posedge ref_clk) disable iff (reset)
      ({pinEn, srcSel} == 2'b10) |-> preTick == (phaseTick && timerPin);
  endproperty
  a_mode_gated: assert property (p_mode_gated) else $error("gated mode input wrong");

  property p_mode_edge;
    @(posedge ref_clk) disable iff (reset)
      ({pinEn, srcSel} == 2'b11) |-> preTick == (timerPin && !s_reg.pinPrev);
  endproperty
  a_mode_edge: assert property (p_mode_edge) else $error("edge mode input wrong");

  // internal clock phase, one tick in four clocks
  property p_tick_period;
    @(posedge ref_clk) disable iff (reset)
      phaseTick |=> (!phaseTick [*3]) ##1 phaseTick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("phase tick period wrong");

  property p_phase_step;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> s_reg.phaseCnt == $past(s_reg.phaseCnt) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase counter skipped");

  // prescaler counting and clearing
  property p_prescaler_step;
    @(posedge ref_clk) disable iff (reset)
      !(wrCtrl && !legacy && wrData[PS_CLR_BIT])
        |=> s_reg.prescaler == $past(s_reg.prescaler) + {6'h0, $past(preTick)};
  endproperty
  a_prescaler_step: assert property (p_prescaler_step) else $error("prescaler step wrong");

  property p_ps_clr_no_tap;
    @(posedge ref_clk) disable iff (reset)
      (wrCtrl && !legacy && wrData[PS_CLR_BIT]) |-> !tapPulse;
  endproperty
  a_ps_clr_no_tap: assert property (p_ps_clr_no_tap) else $error("tap during prescaler clear");

  // option word effects
  property p_init_load;
    @(posedge ref_clk) disable iff (reset)
      $rose(s_reg.initDone) |-> (s_reg.countClockSelect == OPTION_WORD[SRC_BIT])
                             && (s_reg.extPinEnable == OPTION_WORD[PIN_EN_BIT])
                             && (s_reg.divSelect == OPTION_WORD[2:0]);
  endproperty
  a_init_load: assert property (p_init_load) else $error("option bits not loaded");

  property p_osc_copy;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> oscIsRc == OPTION_WORD[OSC_BIT];
  endproperty
  a_osc_copy: assert property (p_osc_copy) else $error("oscillator type output wrong");

endmodule

// [logic/prescaled_down_timer_pkg.sv]
// constants for the prescaled down timer
package prescaled_down_timer_pkg;
  localparam logic [11:0] COUNT_CONTROL_ADDR  = 12'h009;
  localparam logic [11:0] COUNT_VALUE_ADDR    = 12'h008;
  localparam logic [11:0] EPROM_PROG_ADDR     = 12'h00b;
  localparam logic [11:0] OPTION_WORD_ADDR    = 12'hf38;
  localparam int REQ_BIT      = 7;
  localparam int MASK_BIT     = 6;
  localparam int SRC_BIT      = 5;
  localparam int PIN_EN_BIT   = 4;
  localparam int PS_CLR_BIT   = 3;
  localparam int LEGACY_BIT   = 6;
  localparam int OSC_BIT      = 7;
  localparam logic [7:0] OPTION_ERASED  = 8'h00;
  localparam logic [7:0] EPROM_PROG_RST = 8'hff;
  localparam logic [1:0] PHASE_DIV      = 2'h3;   // internal clock is osc/4
  localparam logic [2:0] DIV_SEL_RST    = 3'h0;
  localparam logic [7:0] COUNT_INIT     = 8'hff;
endpackage

// [test/pin_source.sv]
// far-side model: external timer pin source
`timescale 1ns/1ps
module pin_source #(
  parameter int HALF = 4
) (
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      timerPin
);
  int cnt = 0;
  initial timerPin = 1'b0;
  // square wave while run, parked low otherwise
  always @(posedge ref_clk) begin
    if (!run) begin
      timerPin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      timerPin <= !timerPin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [test/prescaled_down_timer_tb.sv]
// self-checking bench for the prescaled down timer
`timescale 1ns/1ps
module prescaled_down_timer_tb;
  import prescaled_down_timer_pkg::*;
  logic        ref_clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0, cpuIntMask = 1, run = 0, rdPend = 0;
  logic [11:0] addr = '0;
  logic [7:0]  wrData = '0, seed = 8'h49, v, rdData, countValue;
  logic [15:0] n;
  logic        timerPin, timerIrq, oscIsRc;
  logic [7:0]  expQ[$];
  int          fails = 0, compares = 0;

  prescaled_down_timer u_dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .timerPin(timerPin),
    .cpuIntMask(cpuIntMask), .timerIrq(timerIrq), .oscIsRc(oscIsRc), .countValue(countValue));
  pin_source u_pin (.ref_clk(ref_clk), .run(run), .timerPin(timerPin));

  // clock generator
  always #2.5 ref_clk = !ref_clk;

  function automatic logic [7:0] lfsr(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(string what, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // one bus cycle; for a read d is the expected answer
  task automatic bus(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge ref_clk);
    wrStrobe <= w;
    rdStrobe <= !w;
    addr <= a;
    wrData <= d;
    if (!w) expQ.push_back(d);
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
  endtask

  task automatic waitChange(output logic [15:0] p);
    v = countValue;
    p = 0;
    while (countValue === v && p < 16'd2000) begin
      @(posedge ref_clk);
      #1;
      p++;
    end
  endtask

  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // compare each read answer with the oldest note
  always @(posedge ref_clk) begin
    if (rdPend) check("rdData", 16'(expQ.pop_front()), 16'(rdData));
    rdPend <= rdStrobe;
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    bus(0, COUNT_CONTROL_ADDR, 8'h40);
    bus(0, OPTION_WORD_ADDR, OPTION_ERASED);
    bus(0, EPROM_PROG_ADDR, EPROM_PROG_RST);
    bus(0, 12'h0a1, 8'h00);
    check("oscIsRc", 16'h0, 16'(oscIsRc));
    bus(1, COUNT_CONTROL_ADDR, 8'h68);
    bus(0, COUNT_CONTROL_ADDR, 8'h60);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1, COUNT_VALUE_ADDR, seed);
      bus(0, COUNT_VALUE_ADDR, seed);
    end
    repeat (50) @(posedge ref_clk);
    check("stopped", 16'(seed), 16'(countValue));
    for (int s = 0; s < 8; s++) begin
      bus(1, COUNT_CONTROL_ADDR, 8'h48 | 8'(s));
      waitChange(n);
      waitChange(n);
      check("period", 16'(4 << s), n);
    end
    bus(1, COUNT_CONTROL_ADDR, 8'h08);
    bus(1, COUNT_VALUE_ADDR, 8'h02);
    repeat (8) if (countValue !== 8'h00) waitChange(n);
    repeat (2) @(posedge ref_clk);
    bus(0, COUNT_CONTROL_ADDR, 8'h80);
    check("irq masked", 16'h0, 16'(timerIrq));
    cpuIntMask <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("irq", 16'h1, 16'(timerIrq));
    check("wrap", 16'hff, 16'(countValue));
    waitChange(n);
    check("wrap step", 16'hfe, 16'(countValue));
    bus(1, COUNT_CONTROL_ADDR, 8'h48);
    repeat (3) @(posedge ref_clk);
    check("irq cleared", 16'h0, 16'(timerIrq));
    bus(0, COUNT_CONTROL_ADDR, 8'h40);
    bus(1, COUNT_CONTROL_ADDR, 8'h78);
    run <= 1'b1;
    waitChange(n);
    waitChange(n);
    check("pin period", 16'd8, n);
    run <= 1'b0;
    bus(1, COUNT_CONTROL_ADDR, 8'h58);
    v = countValue;
    repeat (40) @(posedge ref_clk);
    check("gated", 16'(v), 16'(countValue));
    run <= 1'b1;
    waitChange(n);
    check("gated run", 16'(8'(v - 8'h1)), 16'(countValue));
    stop_test();
  end
endmodule
